// ==== rtl/dcs_chan.v ====
`timescale 1ns/10ps
`default_nettype none
`include "dcs_consts.vh"
// ==========================================
// One integrating channel accumulator
module dcs_chan (
   // Clock and reset
   input  wire        clock,
   input  wire        rst_n,
   input  wire        ce,
   // Control
   input  wire        clear,
   input  wire        count_slot,
   input  wire        gain_low,
   // Photocurrent quanta
   input  wire        light_pulse,
   // Result
   output reg  [15:0] result
);
   reg  [17:0] acc_r;
   reg  [3:0]  pre_r;
   reg         pend_r;
   wire        take;
   wire [17:0] net_cnt;

   // A quantum waits here until the next allowed slot; extra quanta are lost, as a real integrator clips
   assign take = count_slot & (pend_r | light_pulse);

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         acc_r  <= 18'h00000;
         pre_r  <= 4'h0;
         pend_r <= 1'b0;
      end else if (ce) begin
         if (clear) begin
            acc_r  <= 18'h00000;
            pre_r  <= 4'h0;
            pend_r <= 1'b0;
         end else begin
            if (take)
               pend_r <= 1'b0;
            else if (light_pulse)
               pend_r <= 1'b1;
            if (take) begin
               pre_r <= pre_r + 4'h1;
               // Low gain counts one quantum in sixteen
               if ((!gain_low || pre_r == `DCS_LOW_GAIN_DIV) && acc_r != `DCS_ACC_CEIL)
                  acc_r <= acc_r + 18'h00001;
            end
         end
      end
   end

   // Two-count offset, then clamp at the 16-bit ceiling
   assign net_cnt = acc_r - `DCS_COUNT_OFFSET;

   always @* begin
      if (acc_r < `DCS_COUNT_OFFSET)
         result = 16'h0000;
      else if (net_cnt > {2'h0, `DCS_RESULT_MAX})
         result = `DCS_RESULT_MAX;
      else
         result = net_cnt[15:0];
   end
endmodule
`default_nettype wire

// ==== rtl/dcs_consts.vh ====
`ifndef DCS_CONSTS_VH
`define DCS_CONSTS_VH
// ==========================================
// Integration timing, in oscillator cycles
`define DCS_STEP_CYCLES      918
`define DCS_STEPS_SHORT      11
`define DCS_STEPS_MEDIUM     81
`define DCS_STEPS_LONG       322
`define DCS_INT_SHORT        2'h0
`define DCS_INT_MEDIUM       2'h1
`define DCS_INT_LONG         2'h2
// ==========================================
// Result limits
`define DCS_COUNT_OFFSET     18'h00002
`define DCS_RESULT_MAX       16'hFFFF
`define DCS_ACC_CEIL         18'h10001
`define DCS_LOW_GAIN_DIV     4'hF
// ==========================================
// Bus timeout
`define DCS_CLK_MHZ          125
`define DCS_TIMEOUT_MIN_MS   25
`define DCS_TIMEOUT_MAX_MS   35
`endif

// ==== rtl/dcs_sequencer.v ====
`timescale 1ns/10ps
`default_nettype none
`include "dcs_consts.vh"
// Summary of operation
// - One integration lasts 11, 81 or 322 times 918 oscillator cycles for field 00, 01 or 10.
// - A channel gains at most one count per two oscillator cycles and its result is reduced by two counts.
// - Results clamp at 65535 and never wrap.
// - Low gain counts one sixteenth as much as high gain.
// - Both channels start and stop integrating on the same oscillator cycle.
// - At the end of a cycle each channel's result goes to its own data register.
// - Results are double buffered so a read in progress sees a whole old or whole new value.
// - The next integration starts by itself right after the transfer.
// - In SMBus mode a clock or data line held low for 25 to 35 ms is flagged as a timeout.
module dcs_sequencer #(
   parameter STEP_CYCLES = `DCS_STEP_CYCLES,
   parameter TIMEOUT_CYC = `DCS_TIMEOUT_MIN_MS * `DCS_CLK_MHZ * 1000
) (
   // Clock, reset, enable
   input  wire        clock,
   input  wire        rstn,
   input  wire        ce,
   // Converter front end
   input  wire        osc_tick,
   input  wire        broadband_pulse,
   input  wire        infrared_pulse,
   // Settings
   input  wire [1:0]  integ_sel,
   input  wire        gain_low,
   input  wire        smbus_mode,
   // Serial lines and read interlock
   input  wire        scl_in,
   input  wire        sda_in,
   input  wire        host_read_busy,
   // Results
   output reg  [15:0] broadband_channel_r,
   output reg  [15:0] infrared_channel_r,
   output reg         data_new_r,
   output reg         integrating_r,
   output reg         bus_timeout_r
);
   localparam ST_IDLE  = 3'h1;
   localparam ST_INTEG = 3'h2;
   localparam ST_XFER  = 3'h4;

   // ==========================================
   // Derived counts, kept 32 bits wide and sliced where used
   localparam [31:0] CYC_SHORT_W  = `DCS_STEPS_SHORT  * STEP_CYCLES;
   localparam [31:0] CYC_MEDIUM_W = `DCS_STEPS_MEDIUM * STEP_CYCLES;
   localparam [31:0] CYC_LONG_W   = `DCS_STEPS_LONG   * STEP_CYCLES;
   localparam [31:0] TMO_W        = TIMEOUT_CYC;
   localparam [31:0] TMO_LAST_W   = TIMEOUT_CYC - 1;

   reg  [2:0]  state_r;
   reg  [2:0]  state_nxt;
   reg  [1:0]  rst_sync_r;
   wire        rst_n;
   reg  [18:0] cyc_r;
   reg  [18:0] cyc_limit;
   wire [18:0] cyc_last;
   reg         phase_r;
   reg         latch_r;
   reg  [15:0] bb_shadow_r;
   reg  [15:0] ir_shadow_r;
   reg  [21:0] low_cnt_r;
   reg         line_low_r;
   wire [15:0] bb_result;
   wire [15:0] ir_result;
   wire        slot;
   wire        chan_clear;
   wire        last_tick;

   // ==========================================
   // Reset release
   // Entry is immediate, release waits two edges so it never lands near the clock
   always @(posedge clock or negedge rstn) begin
      if (!rstn)
         rst_sync_r <= 2'h0;
      else
         rst_sync_r <= {rst_sync_r[0], 1'b1};
   end
   assign rst_n = rst_sync_r[1];

   // ==========================================
   // Period length
   // Field value 11 leaves the limit at zero, which parks the sequencer
   always @* begin
      case (integ_sel)
         `DCS_INT_SHORT:  cyc_limit = CYC_SHORT_W[18:0];
         `DCS_INT_MEDIUM: cyc_limit = CYC_MEDIUM_W[18:0];
         `DCS_INT_LONG:   cyc_limit = CYC_LONG_W[18:0];
         default:         cyc_limit = 19'h00000;
      endcase
   end

   assign cyc_last   = cyc_limit - 19'h00001;
   assign last_tick  = osc_tick && (cyc_r == cyc_last);
   // One shared pacer keeps both channels on the same count slots
   assign slot       = (state_r == ST_INTEG) && osc_tick && phase_r;
   assign chan_clear = (state_r != ST_INTEG);

   // ==========================================
   // Channels
   // One pacer and one clear feed both, so neither channel can drift from the other
   dcs_chan u_broadband (
      .clock       (clock),
      .rst_n       (rst_n),
      .ce          (ce),
      .clear       (chan_clear),
      .count_slot  (slot),
      .gain_low    (gain_low),
      .light_pulse (broadband_pulse),
      .result      (bb_result)
   );

   dcs_chan u_infrared (
      .clock       (clock),
      .rst_n       (rst_n),
      .ce          (ce),
      .clear       (chan_clear),
      .count_slot  (slot),
      .gain_low    (gain_low),
      .light_pulse (infrared_pulse),
      .result      (ir_result)
   );

   // ==========================================
   // Sequencer
   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            // Unused field value 11 parks the converter
            if (cyc_limit != 19'h00000)
               state_nxt = ST_INTEG;
         end
         ST_INTEG: begin
            if (cyc_limit == 19'h00000)
               state_nxt = ST_IDLE;
            else if (last_tick)
               state_nxt = ST_XFER;
         end
         ST_XFER: begin
            // Wait for any read in flight so the visible word never tears
            // A stalled copy also delays the next period; ticks meanwhile are not counted
            if (!host_read_busy && !latch_r)
               state_nxt = ST_INTEG;
         end
         default: state_nxt = ST_IDLE;
      endcase
   end

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_r       <= ST_IDLE;
         cyc_r         <= 19'h00000;
         phase_r       <= 1'b0;
         integrating_r <= 1'b0;
      end else if (ce) begin
         state_r       <= state_nxt;
         integrating_r <= (state_nxt == ST_INTEG);
         if (state_r != ST_INTEG) begin
            cyc_r   <= 19'h00000;
            phase_r <= 1'b0;
         end else if (osc_tick) begin
            cyc_r   <= cyc_r + 19'h00001;
            phase_r <= ~phase_r;
         end
      end
   end

   // ==========================================
   // Result buffers
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         latch_r             <= 1'b0;
         bb_shadow_r         <= 16'h0000;
         ir_shadow_r         <= 16'h0000;
         broadband_channel_r <= 16'h0000;
         infrared_channel_r  <= 16'h0000;
         data_new_r          <= 1'b0;
      end else if (ce) begin
         data_new_r <= 1'b0;
         // The closing slot lands on the last tick, so the shadows wait one edge to include it
         latch_r    <= (state_r == ST_INTEG) && last_tick;
         // First buffer: both channels frozen on the same edge
         if (latch_r) begin
            bb_shadow_r <= bb_result;
            ir_shadow_r <= ir_result;
         end
         // Second buffer: visible data registers, both words in one edge
         if (state_r == ST_XFER && !latch_r && !host_read_busy) begin
            broadband_channel_r <= bb_shadow_r;
            infrared_channel_r  <= ir_shadow_r;
            data_new_r          <= 1'b1;
         end
      end
   end

   // ==========================================
   // SMBus stuck-low timeout, fired at the low end of the window
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         low_cnt_r     <= 22'h000000;
         line_low_r    <= 1'b0;
         bus_timeout_r <= 1'b0;
      end else if (ce) begin
         line_low_r    <= smbus_mode && (!scl_in || !sda_in);
         bus_timeout_r <= 1'b0;
         // The counter parks at its limit so the pulse cannot repeat while the line stays low
         if (!line_low_r)
            low_cnt_r <= 22'h000000;
         else if (low_cnt_r != TMO_W[21:0]) begin
            low_cnt_r <= low_cnt_r + 22'h000001;
            if (low_cnt_r == TMO_LAST_W[21:0])
               bus_timeout_r <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// ==== test/dcs_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// ========
// Serial host: reads results or stalls the clock line
module dcs_host_model (
   input wire logic        clock,
   input wire logic        read_req,
   input wire logic        hold_go,
   input wire logic [15:0] hold_len,
   output var logic        scl,
   output var logic        busy
);
   int left = 0;
   int ph = 0;
   initial scl = 1'b1;
   initial busy = 1'b0;
   // Released line is pulled up; read clock runs at 100 kHz
   always @(negedge clock) begin
      left = hold_go ? hold_len : (left > 0 ? left - 1 : 0);
      ph = read_req ? ph + 1 : 0;
      busy <= read_req;
      scl <= left == 0 && (ph / 625) % 2 == 0;
   end
endmodule
`default_nettype wire

// ==== test/dcs_sequencer_asserts.sv ====
`timescale 1ns/10ps
`default_nettype none
// ========
// Port checker for the sequencer
module dcs_sequencer_asserts #(parameter int TIMEOUT_CYC = 1000) (
   // Clock, reset, inputs
   input wire logic        clock,
   input wire logic        rstn,
   input wire logic        ce,
   input wire logic        smbus_mode,
   input wire logic        scl_in,
   input wire logic        sda_in,
   input wire logic        host_read_busy,
   // Results
   input wire logic [15:0] broadband_channel_r,
   input wire logic [15:0] infrared_channel_r,
   input wire logic        data_new_r,
   input wire logic        integrating_r,
   input wire logic        bus_timeout_r
);
   int low_r;
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   // Own stuck-low count, since the design's counter is hidden
   always_ff @(posedge clock or negedge rstn)
      if (!rstn) low_r <= 0;
      else low_r <= (smbus_mode && !(scl_in && sda_in)) ? low_r + 1 : 0;
   new_pulse_a: assert property (data_new_r |=> !data_new_r) else $error("new flag too long");
   only_on_new_a: assert property ($changed(broadband_channel_r) || $changed(infrared_channel_r) |-> data_new_r)
      else $error("result moved without flag");
   restart_a: assert property (data_new_r |-> integrating_r) else $error("no restart");
   busy_stall_a: assert property (host_read_busy && $past(host_read_busy) && !integrating_r |=> !data_new_r)
      else $error("copy during read");
   copy_done_a: assert property ($fell(integrating_r) ##1 (ce && !host_read_busy) |=> data_new_r)
      else $error("copy late");
   tmo_pulse_a: assert property (bus_timeout_r |=> !bus_timeout_r) else $error("timeout too long");
   tmo_early_a: assert property (bus_timeout_r |-> low_r >= TIMEOUT_CYC - 2) else $error("timeout early");
   tmo_late_a: assert property (low_r == TIMEOUT_CYC - 2 |-> ##[0:8] bus_timeout_r) else $error("timeout late");
   cover property (data_new_r);
   cover property (bus_timeout_r);
   cover property (host_read_busy && !integrating_r);
endmodule
bind dcs_sequencer dcs_sequencer_asserts #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_chk (.clock, .rstn, .ce, .smbus_mode,
   .scl_in, .sda_in, .host_read_busy, .broadband_channel_r, .infrared_channel_r, .data_new_r, .integrating_r,
   .bus_timeout_r);
`default_nettype wire

// ==== test/tb_dual_channel_integration_sequencer.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_dual_channel_integration_sequencer;
   localparam int STEP = 4;
   logic        clock = 1'b0, rstn = 1'b0, osc_tick = 1'b0, broadband_pulse = 1'b0, infrared_pulse = 1'b0;
   logic        gain_low = 1'b0, smbus_mode = 1'b0, rd = 1'b0, go = 1'b0, gen = 1'b0, sda = 1'b1;
   logic [1:0]  integ_sel = 2'h0;
   logic [15:0] hl = 16'h0000, broadband_channel_r, infrared_channel_r;
   logic        scl_in, host_read_busy, data_new_r, integrating_r, bus_timeout_r;
   int          failures = 0, checks_done = 0, seed = 67, cyc = 0, idx = 0, nper = 4, nd = 0, nt = 0;
   int          ab = 0, ai = 0, pb = 0, pi = 0, qb[$], qi[$];
   dcs_sequencer #(.STEP_CYCLES(STEP), .TIMEOUT_CYC(1000)) dut (.clock, .rstn, .ce(1'b1), .osc_tick,
      .broadband_pulse, .infrared_pulse, .integ_sel, .gain_low, .smbus_mode, .scl_in, .sda_in(sda),
      .host_read_busy, .broadband_channel_r, .infrared_channel_r, .data_new_r, .integrating_r, .bus_timeout_r);
   dcs_host_model host (.clock, .read_req(rd), .hold_go(go), .hold_len(hl), .scl(scl_in), .busy(host_read_busy));
   always #4 clock = ~clock;
   // ========
   // Reference result from taken quanta
   function automatic int res(int t);
      int r;
      r = gain_low ? t / 16 : t;
      r = r > 65537 ? 65537 : r;
      return r < 2 ? 0 : r - 2;
   endfunction
   task automatic chk(string nm, int e, logic [15:0] g);
      checks_done++;
      if (g !== e[15:0]) begin
         failures++;
         $display("ERROR %s expected %0d seen %0d", nm, e, g);
      end
   endtask
   task finish_test;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // ========
   // Ticks every 4 clocks; one quantum at most before each slot, so none is lost
   always @(negedge clock) begin
      cyc++;
      if (data_new_r === 1'b1) begin
         nd++;
         chk("broadband", qb.size() ? qb.pop_front() : -1, broadband_channel_r);
         chk("infrared", qi.size() ? qi.pop_front() : -1, infrared_channel_r);
      end
      if (bus_timeout_r === 1'b1) nt++;
      osc_tick <= gen && cyc % 4 == 0;
      broadband_pulse <= 1'b0;
      infrared_pulse <= 1'b0;
      if (gen && cyc % 4 == 0) begin
         ab += idx % 2 ? pb : 0;
         ai += idx % 2 ? pi : 0;
         idx++;
         if (idx == nper) begin
            qb.push_back(res(ab));
            qi.push_back(res(ai));
            idx = 0;
            ab = 0;
            ai = 0;
         end
      end
      if (gen && cyc % 4 == 2 && idx % 2) begin
         pb = $random(seed) & 1;
         pi = $random(seed) & 1;
         broadband_pulse <= pb[0];
         infrared_pulse <= pi[0];
      end
   end
   always @(negedge clock) if (cyc > 60000) begin
      failures++;
      finish_test();
   end
   task automatic start(int s, int g);
      gen <= 1'b0;
      rstn <= 1'b0;
      integ_sel <= s[1:0];
      gain_low <= g[0];
      repeat (16) @(negedge clock);
      rstn <= 1'b1;
      for (int k = 0; k < 12 && integrating_r !== 1'b1; k++) @(negedge clock);
      idx = 0;
      ab = 0;
      ai = 0;
      nd = 0;
      qb.delete();
      qi.delete();
      nper = (s == 0 ? 11 : s == 1 ? 81 : 322) * STEP;
      gen <= 1'b1;
   endtask
   initial begin
      for (int s = 0; s < 6; s++) begin
         start(s % 3, s / 3);
         repeat (2 * nper * 4 + 40) @(negedge clock);
         chk("periods", 2, 16'(nd));
      end
      start(0, 0);
      repeat (nper * 4 - 20) @(negedge clock);
      rd <= 1'b1;
      repeat (60) @(negedge clock);
      chk("stalled", 0, 16'(nd));
      rd <= 1'b0;
      repeat (8) @(negedge clock);
      chk("released", 1, 16'(nd));
      start(3, 0);
      for (int k = 0; k < 3; k++) begin
         smbus_mode <= (k < 2);
         hl <= k > 0 ? 16'h044C : 16'h0384;
         go <= 1'b1;
         nt = 0;
         @(negedge clock);
         go <= 1'b0;
         repeat (1200) @(negedge clock);
         chk("timeout", k == 1, 16'(nt));
      end
      smbus_mode <= 1'b1;
      sda <= 1'b0;
      nt = 0;
      repeat (1100) @(negedge clock);
      sda <= 1'b1;
      repeat (100) @(negedge clock);
      chk("sda timeout", 1, 16'(nt));
      finish_test();
   end
endmodule
`default_nettype wire
